// ---- hw/mcio_cfg.svh ----
// Constants for the memory controller I/O sequencer: offsets, fields, codes, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef MCIO_CFG_SVH
`define MCIO_CFG_SVH
// Timing: system clock, the 20 MHz sequencing tick and the 4 MHz CPU cycle.
`define CLK_PERIOD_NS    8
`define TICK_PERIOD_NS   50
`define CPU_PERIOD_NS    250
`define TICK_DIV         (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define CPU_TICKS        (`CPU_PERIOD_NS / `TICK_PERIOD_NS)
`define CPU_LOW_TICKS    3
`define STROBE_TICKS     2
`define COUNT_PRESET     4'h1
`define COUNT_LAST       4'h8
// Register byte offsets.
`define OFS_UWORD        8'h00
`define OFS_CPU_OUT      8'h04
`define OFS_ADDR         8'h08
`define OFS_STATUS       8'h0C
`define OFS_RDATA        8'h10
`define OFS_PORT         8'h14
// Microword field positions.
`define UW_PORT_EN       0
`define UW_IRQ           1
`define UW_READ_EN       2
`define UW_WRITE_EN      3
`define UW_BUF_SEL       4
`define UW_RUN           5
`define UW_KIND_LSB      8
`define UW_RESET         32'h0000_0020
// Report kinds and status codes.
`define KIND_RAW         4'h0
`define KIND_OK          4'h1
`define KIND_DEFECT_OVW  4'h2
`define KIND_HORIZ_OVW   4'h3
`define KIND_UPPER_OVW   4'h4
`define KIND_LOWER_OVW   4'h5
`define KIND_DEFECT_FULL 4'h6
`define KIND_NO_DATA     4'h7
`define KIND_MEM_ERR     4'h8
`define KIND_CPU_ERR     4'h9
`define KIND_MAX_COUNT   4'hA
`define ST_OK            16'h0000
`define ST_DEFECT_OVW    16'h0001
`define ST_HORIZ_OVW     16'h0002
`define ST_UPPER_OVW     16'h0004
`define ST_LOWER_OVW     16'h0008
`define ST_DEFECT_FULL   16'h0010
`define ST_NO_DATA       16'h0020
`define ST_MEM_ERR       16'h0080
`define ST_CPU_ERR       16'h0100
`define NARROW_BITS      10
`endif

// ---- hw/mcio_pkg.sv ----
// Types shared by the memory controller I/O sequencer.
// Assumes mcio_cfg.svh is on the include path.
`include "mcio_cfg.svh"
package mcio_pkg;
	typedef enum logic [3:0] {
		DMC_IDLE  = 4'b0001,
		DMC_LOAD  = 4'b0010,
		DMC_ENABLE = 4'b0100,
		DMC_DATA  = 4'b1000
	} dmc_state_e;

	typedef struct packed {
		logic        chip_enable;
		logic        write_enable_n;
		logic        read_n;
		logic        data_latch_en;
		logic        counter_load_n;
		logic [3:0]  chip_sel;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mem_ctl_s;
endpackage : mcio_pkg

// ---- hw/memory_controller_io_sequencer.sv ----
// Host-port reporting and data-memory cycle sequencing, reached over APB.
// Assumes one 125 MHz clock; the 20 MHz and 4 MHz rates are enable ticks.
`timescale 1ns/1ps
`default_nettype none
`include "mcio_cfg.svh"

// Overview of operation
// - A routine ending without error loads status 0000 into the host port.
// - Overwrite faults report 0001, 0002, 0004 or 0008 by array.
// - Full defect array reports 0010; no usable data reports 0020.
// - Self-test reports memory failure as 080 and processor failure as 0100.
// - Each routine loads its 16-bit status word and interrupts the host on the same clock.
// - Maximum point count goes into the host port with no interrupt.
// - At power-up the firmware release number sits in the host port.
// - Port load strobe is port enable AND cycle strobe AND inverted CPU clock.
// - Cycle strobe is high two 20 MHz ticks, starting only as the sequencing clock falls.
// - Interrupt comes from the microword bit, then the block waits for the host.
// - Write flag latches direction from read/write bits at memory-cycle clock rise.
// - Memory-cycle clock is inverted CPU clock AND cycle strobe.
// - Inverted active-low write enable serves as the memory read control line.
// - Control machine idles until read or write enable, then moves on cycle clock.
// - Second state asserts counter load, presetting the counter to one.
// - Third state is entered only once the sequencing clock is low.
// - Third state asserts load and chip enable; writes enable the data latch next.
// - Chip enable and latch enable hold until the count reaches eight.
// - Address register loads by a gated strobe; high bits decode chip selects.
// - Buffer select high writes acquisition data, low writes CPU output.
// - Reads in the lowest 4K return zeros above the low ten bits.
module memory_controller_io_sequencer
	import mcio_pkg::*;
#(
	parameter int          ADDR_W      = 16,
	parameter logic [15:0] RELEASE_NUM = 16'h0001 // Arbitrary value.
) (
	input  wire logic              i_clk,
	input  wire logic              i_rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              i_host_ack,
	input  wire logic [15:0]       i_acq_data,
	input  wire logic [15:0]       i_mem_rdata,
	output logic      [15:0]       o_host_port,
	output logic                   o_host_irq,
	output logic                   o_sequencing_clock_out,
	output logic                   o_cycle_strobe,
	output mem_ctl_s               o_mem
);
	localparam int TICK_DIV  = (`TICK_DIV < 1) ? 1 : `TICK_DIV;
	localparam int CPU_TICKS = `CPU_TICKS;

	logic [3:0]  div_reg;
	logic        tick;
	logic [2:0]  phase_reg;
	logic        cpu_clk_reg;
	logic [1:0]  strobe_cnt_reg;
	logic        cycle_strobe_reg;
	logic        mcc_reg;
	logic        mcc_rise;
	logic        port_load_reg;
	logic [31:0] uword_reg;
	logic        uword_pending_reg;
	logic        waiting_reg;
	logic [15:0] cpu_out_reg;
	logic [15:0] addr_reg;
	logic        addr_pending_reg;
	logic [15:0] host_port_reg;
	logic        irq_reg;
	logic        write_direction_flag;
	logic        buf_sel_reg;
	dmc_state_e  dmc_reg;
	logic [3:0]  count_reg;
	logic [15:0] rdata_reg;
	mem_ctl_s    mem_reg;
	logic [15:0] status_code;
	logic        apb_wr;
	logic [31:0] rd_next;
	logic        hit;
	logic        take_uword;
	logic        strobe_end;
	logic        irq_arm_reg;

	// The 20 MHz tick; a 125 MHz clock does not divide evenly, so the tick runs slightly fast.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_reg <= 4'h0;
		end else if (tick) begin
			div_reg <= 4'h0;
		end else begin
			div_reg <= div_reg + 4'h1;
		end
	end
	assign tick = (div_reg == 4'(TICK_DIV - 1));

	// Sequencing clock: five ticks per CPU cycle, low for the first three.
	// Clearing the run bit freezes the phase; the strobe and a memory cycle past its load state still run out on the tick.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			phase_reg   <= 3'h0;
			cpu_clk_reg <= 1'b1;
		end else if (tick && uword_reg[`UW_RUN]) begin
			if (phase_reg == 3'(CPU_TICKS - 1)) begin
				phase_reg   <= 3'h0;
				cpu_clk_reg <= 1'b0;
			end else begin
				phase_reg   <= phase_reg + 3'h1;
				cpu_clk_reg <= (phase_reg + 3'h1 >= 3'(`CPU_LOW_TICKS));
			end
		end
	end

	// Cycle strobe starts only as the sequencing clock goes low, and lasts two ticks.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			strobe_cnt_reg   <= 2'h0;
			cycle_strobe_reg <= 1'b0;
		end else if (tick) begin
			if (uword_reg[`UW_RUN] && phase_reg == 3'(CPU_TICKS - 1)) begin
				strobe_cnt_reg   <= 2'(`STROBE_TICKS - 1);
				cycle_strobe_reg <= 1'b1;
			end else if (strobe_cnt_reg != 2'h0) begin
				strobe_cnt_reg <= strobe_cnt_reg - 2'h1;
			end else begin
				cycle_strobe_reg <= 1'b0;
			end
		end
	end

	// Memory-cycle clock; its rising edge starts a cycle.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mcc_reg <= 1'b0;
		end else begin
			mcc_reg <= cycle_strobe_reg & ~cpu_clk_reg;
		end
	end
	assign mcc_rise   = cycle_strobe_reg & ~cpu_clk_reg & ~mcc_reg;
	// A pending microword is applied once, at the start of a cycle, unless parked.
	assign take_uword = mcc_rise & uword_pending_reg & ~waiting_reg;

	// Last tick of the strobe, with the sequencing clock still low: the end of the cycle.
	// Port load and interrupt both key off this edge, so the host never sees them apart.
	assign strobe_end = tick & cycle_strobe_reg & ~cpu_clk_reg & (strobe_cnt_reg == 2'h0);

	// Port strobe: armed by the port-enable bit at cycle start, spent at the strobe end.
	// A one-clock pulse would miss the end tick, so the arm is held across the strobe.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			port_load_reg <= 1'b0;
		end else if (take_uword && uword_reg[`UW_PORT_EN]) begin
			port_load_reg <= 1'b1;
		end else if (strobe_end) begin
			port_load_reg <= 1'b0;
		end
	end

	// Interrupt request: armed at cycle start, never for the maximum point count report.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_arm_reg <= 1'b0;
		end else if (take_uword && uword_reg[`UW_IRQ]
			&& uword_reg[`UW_KIND_LSB +: 4] != `KIND_MAX_COUNT) begin
			irq_arm_reg <= 1'b1;
		end else if (strobe_end) begin
			irq_arm_reg <= 1'b0;
		end
	end

	// Status code lookup for the report kinds.
	always_comb begin
		unique case (uword_reg[`UW_KIND_LSB +: 4])
			`KIND_OK:          status_code = `ST_OK;
			`KIND_DEFECT_OVW:  status_code = `ST_DEFECT_OVW;
			`KIND_HORIZ_OVW:   status_code = `ST_HORIZ_OVW;
			`KIND_UPPER_OVW:   status_code = `ST_UPPER_OVW;
			`KIND_LOWER_OVW:   status_code = `ST_LOWER_OVW;
			`KIND_DEFECT_FULL: status_code = `ST_DEFECT_FULL;
			`KIND_NO_DATA:     status_code = `ST_NO_DATA;
			`KIND_MEM_ERR:     status_code = `ST_MEM_ERR;
			`KIND_CPU_ERR:     status_code = `ST_CPU_ERR;
			default:           status_code = cpu_out_reg;
		endcase
	end

	// Host port: release number from reset, then loaded at the end of the strobe.
	// A microword rewritten before the strobe ends changes the word that is loaded.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			host_port_reg <= RELEASE_NUM;
		end else if (port_load_reg && strobe_end) begin
			host_port_reg <= status_code;
		end
	end

	// Interrupt follows the loaded word and parks the block until the host answers.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			irq_reg     <= 1'b0;
			waiting_reg <= 1'b0;
		end else if (irq_arm_reg && strobe_end) begin
			irq_reg     <= 1'b1;
			waiting_reg <= 1'b1;
		end else if (i_host_ack) begin
			irq_reg     <= 1'b0;
			waiting_reg <= 1'b0;
		end
	end

	// Write flag latches the transfer direction at the memory-cycle clock rise.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			write_direction_flag <= 1'b0;
			buf_sel_reg          <= 1'b0;
		end else if (take_uword && (uword_reg[`UW_READ_EN] || uword_reg[`UW_WRITE_EN])
			&& dmc_reg == DMC_IDLE) begin
			write_direction_flag <= uword_reg[`UW_WRITE_EN];
			buf_sel_reg          <= uword_reg[`UW_BUF_SEL];
		end
	end

	// Memory control machine: idle, load, chip enable, data phase.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dmc_reg <= DMC_IDLE;
		end else begin
			unique case (dmc_reg)
				DMC_IDLE: begin
					if (take_uword && (uword_reg[`UW_READ_EN] || uword_reg[`UW_WRITE_EN]))
						dmc_reg <= DMC_LOAD;
				end
				DMC_LOAD: begin
					if (tick && !cpu_clk_reg)
						dmc_reg <= DMC_ENABLE;
				end
				DMC_ENABLE: begin
					if (tick)
						dmc_reg <= DMC_DATA;
				end
				DMC_DATA: begin
					if (tick && count_reg == `COUNT_LAST)
						dmc_reg <= DMC_IDLE;
				end
				default: dmc_reg <= DMC_IDLE;
			endcase
		end
	end

	// Cycle counter: preset while loading, counts each tick in the data phase.
	// The count stops at eight so a late tick cannot wrap it back to the preset.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			count_reg <= `COUNT_PRESET;
		end else if (dmc_reg == DMC_LOAD || dmc_reg == DMC_ENABLE) begin
			count_reg <= `COUNT_PRESET;
		end else if (dmc_reg == DMC_DATA && tick && count_reg != `COUNT_LAST) begin
			count_reg <= count_reg + 4'h1;
		end
	end

	// Memory pins, all registered so the array sees clean levels.
	// The pins lag the state by one clock; the counter load pulse lags with them.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mem_reg <= '{chip_enable: 1'b0, write_enable_n: 1'b1, read_n: 1'b0,
				data_latch_en: 1'b0, counter_load_n: 1'b1, chip_sel: 4'h0,
				addr: 16'h0000, wdata: 16'h0000};
		end else begin
			mem_reg.counter_load_n <= ~(dmc_reg == DMC_LOAD || dmc_reg == DMC_ENABLE);
			mem_reg.chip_enable    <= (dmc_reg == DMC_ENABLE || dmc_reg == DMC_DATA);
			mem_reg.data_latch_en  <= (dmc_reg == DMC_DATA) & write_direction_flag;
			mem_reg.write_enable_n <= ~write_direction_flag;
			mem_reg.read_n         <= write_direction_flag;
			mem_reg.addr           <= addr_reg;
			mem_reg.chip_sel       <= 4'h1 << addr_reg[ADDR_W-1 -: 2];
			mem_reg.wdata          <= buf_sel_reg ? i_acq_data : cpu_out_reg;
		end
	end

	// Read data captured on the last data tick; the narrow region reads high bits as zero.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rdata_reg <= 16'h0000;
		end else if (dmc_reg == DMC_DATA && tick && count_reg == `COUNT_LAST
			&& !write_direction_flag) begin
			if (addr_reg[ADDR_W-1:12] == '0) begin
				rdata_reg <= {6'h00, i_mem_rdata[`NARROW_BITS-1:0]};
			end else begin
				rdata_reg <= i_mem_rdata;
			end
		end
	end

	// Address register loads through its own gated strobe, never mid-cycle.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			addr_reg <= 16'h0000;
		end else if (addr_pending_reg && mcc_rise && dmc_reg == DMC_IDLE) begin
			addr_reg <= cpu_out_reg;
		end
	end

	// APB slave: no wait states, answer built in the setup cycle.
	assign apb_wr = psel & penable & pready & pwrite;
	always_comb begin
		hit     = 1'b1;
		rd_next = 32'h0000_0000;
		unique case (paddr)
			`OFS_UWORD:   rd_next = uword_reg;
			`OFS_CPU_OUT: rd_next = {16'h0000, cpu_out_reg};
			`OFS_ADDR:    rd_next = {16'h0000, addr_reg};
			`OFS_STATUS:  rd_next = {18'h0, dmc_reg, 1'b0, write_direction_flag,
				addr_pending_reg, uword_pending_reg, count_reg, waiting_reg, irq_reg};
			`OFS_RDATA:   rd_next = {16'h0000, rdata_reg};
			`OFS_PORT:    rd_next = {16'h0000, host_port_reg};
			default:      hit = 1'b0;
		endcase
	end

	// Answer registers stand for one cycle, the access cycle of each transfer.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			prdata  <= (psel & ~penable & ~pwrite) ? rd_next : 32'h0000_0000;
		end
	end

	// Software-written registers; a new write wins over the consumption in the same cycle.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			uword_reg         <= `UW_RESET;
			uword_pending_reg <= 1'b0;
			cpu_out_reg       <= 16'h0000;
			addr_pending_reg  <= 1'b0;
		end else begin
			if (take_uword)
				uword_pending_reg <= 1'b0;
			if (addr_pending_reg && mcc_rise && dmc_reg == DMC_IDLE)
				addr_pending_reg <= 1'b0;
			if (apb_wr && !pslverr) begin
				unique case (paddr)
					`OFS_UWORD: begin
						uword_reg         <= pwdata;
						uword_pending_reg <= 1'b1;
					end
					`OFS_CPU_OUT: cpu_out_reg <= pwdata[15:0];
					`OFS_ADDR: begin
						cpu_out_reg      <= pwdata[15:0];
						addr_pending_reg <= 1'b1;
					end
					default: ;
				endcase
			end
		end
	end

	// Every pin comes straight from its register.
	assign o_host_port            = host_port_reg;
	assign o_host_irq             = irq_reg;
	assign o_sequencing_clock_out = cpu_clk_reg;
	assign o_cycle_strobe         = cycle_strobe_reg;
	assign o_mem                  = mem_reg;
endmodule : memory_controller_io_sequencer
`default_nettype wire

// ---- sim/mcio_partner.sv ----
// Host and data memory stand-in facing the sequencer pins.
// Assumes the clock of the block; memory keeps 256 words of the space.
`timescale 1ns/1ps
`default_nettype none
module mcio_partner
	import mcio_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire mem_ctl_s    i_mem,
	input  wire logic        i_irq,
	output logic      [15:0] o_rdata,
	output logic             o_ack
);
	logic [15:0] mem [256];
	logic [15:0] last;
	logic [3:0]  dly;
	logic [7:0]  idx;
	assign idx = {i_mem.addr[15], i_mem.addr[6:0]};
	// The host answers an interrupt late so the bench can see it held.
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			dly <= 4'h0;
			o_ack <= 1'b0;
		end else begin
			dly <= i_irq ? dly + 4'h1 : 4'h0;
			o_ack <= i_irq && dly == 4'hF;
		end
	end
	// Writes land while the data latch passes data through.
	always_ff @(posedge i_clk) begin
		if (i_mem.chip_enable && i_mem.data_latch_en)
			mem[idx] <= i_mem.wdata;
		last <= o_rdata;
	end
	// The narrow region floats its top lines, so a nonzero pattern shows there.
	always_comb begin
		if (i_mem.chip_enable && !i_mem.read_n)
			o_rdata = i_mem.addr < 16'h1000 ? {6'h15, mem[idx][9:0]} : mem[idx];
		else
			o_rdata = ~last;
	end
endmodule : mcio_partner
`default_nettype wire

// ---- sim/mcio_props.sv ----
// Checker of the sequencer pins: strobe, host port, interrupt, memory cycle.
// Assumes the six-clock tick and registered pins of the hand-over.
`timescale 1ns/1ps
`default_nettype none
module mcio_props
	import mcio_pkg::*;
(
	input wire logic        i_clk,
	input wire logic        i_rstn,
	input wire logic        i_host_ack,
	input wire logic [15:0] o_host_port,
	input wire logic        o_host_irq,
	input wire logic        o_sequencing_clock_out,
	input wire logic        o_cycle_strobe,
	input wire mem_ctl_s    o_mem
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Counts chip enable clocks; a long repetition would slow the tools.
	logic [7:0] ce_cnt;
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			ce_cnt <= 8'h00;
		else
			ce_cnt <= o_mem.chip_enable ? ce_cnt + 8'h01 : 8'h00;
	end
	property p_strb_len;
		$rose(o_cycle_strobe) |-> o_cycle_strobe[*8] ##1 o_cycle_strobe[*4] ##1 !o_cycle_strobe;
	endproperty
	a_strb_len: assert property (p_strb_len) else $error("strobe length wrong");
	property p_strb_low;
		$rose(o_cycle_strobe) |-> !o_sequencing_clock_out;
	endproperty
	a_strb_low: assert property (p_strb_low) else $error("strobe before clock low");
	property p_port;
		$changed(o_host_port) |-> $past(o_cycle_strobe);
	endproperty
	a_port: assert property (p_port) else $error("port loaded off strobe");
	property p_irq_hold;
		o_host_irq && !i_host_ack |=> o_host_irq;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");
	property p_irq_src;
		$rose(o_host_irq) |-> $fell(o_cycle_strobe);
	endproperty
	a_irq_src: assert property (p_irq_src) else $error("irq off strobe");
	property p_rd_line;
		o_mem.read_n == !o_mem.write_enable_n;
	endproperty
	a_rd_line: assert property (p_rd_line) else $error("read line wrong");
	property p_load;
		$fell(o_mem.counter_load_n) && !o_mem.chip_enable |-> o_cycle_strobe && !o_sequencing_clock_out;
	endproperty
	a_load: assert property (p_load) else $error("cycle start off clock");
	property p_ce_on;
		$rose(o_mem.chip_enable) |-> !o_sequencing_clock_out && !o_mem.counter_load_n;
	endproperty
	a_ce_on: assert property (p_ce_on) else $error("enable too soon");
	property p_latch;
		o_mem.data_latch_en |-> o_mem.chip_enable && !o_mem.write_enable_n;
	endproperty
	a_latch: assert property (p_latch) else $error("latch outside write");
	property p_ce_len;
		$fell(o_mem.chip_enable) |-> ce_cnt inside {[8'd42:8'd60]} && !o_mem.data_latch_en;
	endproperty
	a_ce_len: assert property (p_ce_len) else $error("access length wrong");
	property p_cs;
		o_mem.chip_enable |-> o_mem.chip_sel == 4'h1 << o_mem.addr[15:14];
	endproperty
	a_cs: assert property (p_cs) else $error("chip select wrong");
	c_irq: cover property ($rose(o_host_irq));
	c_wr: cover property ($rose(o_mem.data_latch_en));
	c_rd: cover property ($rose(o_mem.chip_enable) && o_mem.write_enable_n);
endmodule : mcio_props
bind memory_controller_io_sequencer mcio_props mcio_props_inst (.i_clk, .i_rstn, .i_host_ack,
	.o_host_port, .o_host_irq, .o_sequencing_clock_out, .o_cycle_strobe, .o_mem);
`default_nettype wire

// ---- sim/tb_memory_controller_io_sequencer.sv ----
// Self-checking bench of the sequencer, driven over APB.
// Assumes the partner model answers interrupts and memory cycles.
`timescale 1ns/1ps
`default_nettype none
`include "mcio_cfg.svh"
module tb_memory_controller_io_sequencer;
	import mcio_pkg::*;
	logic        i_clk, i_rstn, psel, penable, pwrite, pready, pslverr, ack, irq, sl;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] port, rdata, wd;
	mem_ctl_s    mem;
	int          miscompares, n_tests;
	memory_controller_io_sequencer #(.RELEASE_NUM(16'h0C31)) memory_controller_io_sequencer_inst (
		.i_clk(i_clk), .i_rstn(i_rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.i_host_ack(ack), .i_acq_data(16'hBEEF), .i_mem_rdata(rdata), .o_host_port(port),
		.o_host_irq(irq), .o_sequencing_clock_out(), .o_cycle_strobe(), .o_mem(mem));
	mcio_partner mcio_partner_inst (.i_clk(i_clk), .i_rstn(i_rstn), .i_mem(mem), .i_irq(irq),
		.o_rdata(rdata), .o_ack(ack));
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_tests++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// A wait that runs out is a mismatch and ends the run through the verdict.
	task automatic give_up(input string nm);
		miscompares++;
		$display("CHECK FAILED %s expected answer seen timeout", nm);
		conclude();
	endtask : give_up
	// One APB transfer; the request holds until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk);
		penable <= 1'b1;
		n = 0;
		do @(posedge i_clk); while (pready !== 1'b1 && ++n < 20);
		if (pready !== 1'b1)
			give_up("pready");
		q = prdata;
		sl = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Waits until the interrupt shows a level; running out counts as a mismatch.
	task automatic wait_irq(input logic v);
		int n;
		n = 0;
		while (irq !== v) begin
			if (n > 600)
				give_up("irq");
			@(posedge i_clk);
			n++;
		end
	endtask : wait_irq
	task automatic t_reset();
		chk("release", 16'h0C31, port);
		apb(1'b0, 8'h18, 32'h0);
		chk("slverr", 1'b1, sl);
		chk("unmapped", 32'h0, q);
	endtask : t_reset
	task automatic t_status();
		logic [15:0] e [10] = '{16'hA5C3, 16'h0000, 16'h0001, 16'h0002, 16'h0004,
			16'h0008, 16'h0010, 16'h0020, 16'h0080, 16'h0100};
		apb(1'b1, `OFS_CPU_OUT, 32'hA5C3);
		for (int k = 0; k < 10; k++) begin
			apb(1'b1, `OFS_UWORD, (32'(k) << 8) | 32'h23);
			wait_irq(1'b1);
			chk("status", e[k], port);
			repeat (8) @(posedge i_clk);
			chk("irq", 1'b1, irq);
			wait_irq(1'b0);
		end
	endtask : t_status
	task automatic t_max();
		apb(1'b1, `OFS_CPU_OUT, 32'h0321);
		apb(1'b1, `OFS_UWORD, 32'hA23);
		for (int n = 0; port[9] !== 1'b1; n++) begin
			if (n > 600)
				give_up("max_port");
			@(posedge i_clk);
		end
		chk("max_port", 16'h0321, port);
		repeat (40) @(posedge i_clk);
		chk("max_irq", 1'b0, irq);
	endtask : t_max
	// Runs one memory cycle and keeps the word seen at the write latch.
	task automatic mcyc(input logic [15:0] a, input logic [15:0] d, input logic [31:0] uw);
		wd = 16'h0;
		apb(1'b1, `OFS_ADDR, {16'h0, a});
		// The address comes from the CPU output, so it must land before the data is written.
		for (int n = 0; n < 50; n++) begin
			apb(1'b0, `OFS_STATUS, 32'h0);
			if (q[7] === 1'b0)
				break;
		end
		if (q[7] !== 1'b0)
			give_up("addr_pending");
		apb(1'b1, `OFS_CPU_OUT, {16'h0, d});
		apb(1'b1, `OFS_UWORD, uw);
		for (int n = 0; mem.chip_enable !== 1'b1; n++) begin
			if (n > 600)
				give_up("chip_enable");
			@(posedge i_clk);
		end
		for (int n = 0; n < 200 && mem.chip_enable === 1'b1; n++) begin
			@(posedge i_clk);
			if (mem.data_latch_en === 1'b1)
				wd = mem.wdata;
		end
	endtask : mcyc
	task automatic t_write();
		mcyc(16'h8020, 16'h5A5A, 32'h28);
		chk("wdata_cpu", 16'h5A5A, wd);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk("dir_write", 1'b1, q[8]);
		mcyc(16'h8024, 16'h0000, 32'h38);
		chk("wdata_buf", 16'hBEEF, wd);
		mcyc(16'h0010, 16'hFFFF, 32'h28);
	endtask : t_write
	task automatic t_read();
		mcyc(16'h8020, 16'h0000, 32'h24);
		apb(1'b0, `OFS_RDATA, 32'h0);
		chk("rdata", 32'h5A5A, q);
		apb(1'b0, `OFS_STATUS, 32'h0);
		chk("dir_read", 1'b0, q[8]);
		mcyc(16'h0010, 16'h0000, 32'h24);
		apb(1'b0, `OFS_RDATA, 32'h0);
		chk("rdata_narrow", 32'h03FF, q);
	endtask : t_read
	// A hang counts as a mismatch and ends the run through the same task.
	initial begin
		#100us;
		miscompares++;
		conclude();
	end
	initial begin
		{i_rstn, psel, penable, pwrite, paddr, pwdata} = '0;
		miscompares = 0;
		n_tests = 0;
		repeat (4) @(posedge i_clk);
		i_rstn <= 1'b1;
		t_reset();
		t_status();
		t_max();
		t_write();
		t_read();
		conclude();
	end
endmodule : tb_memory_controller_io_sequencer
`default_nettype wire
